// >>> hw/peig_params.svh
`ifndef PEIG_PARAMS_SVH
`define PEIG_PARAMS_SVH
// Contract
// - OR each function's sources onto its bit
// - Source holds 1 until software clears it
// - Merge core interrupt output into legacy input
// - Write MSI pending register on every change; here changes made while a write is outstanding go out merged in the next write
// - Table entry: 64-bit address, data, mask dword
// - Pending array takes 32-bit and 64-bit accesses; here 32-bit AXI4-Lite reads only, writes have no effect
// - Masked vector stays pending, sends when unmasked
// - Application holds MSI-X table and pending array
// - Read entry, set pending, send memory write
// - Clear pending bit after the write went out

// Own register map, byte addresses on the AXI4-Lite slave
`define PEIG_REG_CTRL 16'h0000
`define PEIG_REG_SRC 16'h0004
`define PEIG_REG_MSI 16'h0008
`define PEIG_REG_STAT 16'h000C
`define PEIG_PBA_PAGE 8'h10
`define PEIG_CTRL_LEG_BIT 0
`define PEIG_CTRL_MSIX_BIT 1
`define PEIG_LEG_EN_RST 1'b1
`define PEIG_MSIX_EN_RST 1'b0
`define PEIG_STAT_CORE_BIT 0
`define PEIG_STAT_BUSY_BIT 1
`define PEIG_STAT_LVL_POS 8
`define PEIG_MX_MASK_BIT 0
`define PEIG_MX_DWORDS 4
`define PEIG_RESP_OKAY 2'b00
`define PEIG_RESP_SLVERR 2'b10
// Device-side legacy wire select register
`define PEIG_DEV_INTX_SEL_OFS 16'h0050
`define PEIG_DEV_INTX_SEL_LSB 8
`define PEIG_DEV_INTX_SEL_MSB 9
`endif

// >>> hw/peig_pkg.sv
package peig_pkg;
    typedef enum logic [2:0] {
        PEIG_IDLE = 3'b000,
        PEIG_CHK = 3'b001,
        PEIG_RD = 3'b010,
        PEIG_SEND = 3'b011
    } peig_mx_st_t;
endpackage : peig_pkg

// >>> hw/peig_tbl_mem.sv
module peig_tbl_mem #(
    parameter int DEPTH = 8192,
    parameter int AW = 13
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic [AW-1:0] ra_addr,
    output logic [31:0] ra_data,
    input wire logic [AW-1:0] rb_addr,
    output logic [31:0] rb_data
);
    if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_chk
        $error("peig_tbl_mem: depth does not fit address width");
    end

    logic [31:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        for (int b = 0; b < 4; b++) begin
            if (we && wstrb[b]) begin
                mem[waddr][b*8 +: 8] <= wdata[b*8 +: 8];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ra_data <= 32'h0000_0000;
            rb_data <= 32'h0000_0000;
        end else begin
            ra_data <= mem[ra_addr];
            rb_data <= mem[rb_addr];
        end
    end
endmodule : peig_tbl_mem

// >>> hw/peig_pba.sv
module peig_pba #(
    parameter int VEC = 2048,
    parameter int VW = 11,
    parameter int PWW = 6
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic set_valid,
    input wire logic [VW-1:0] set_idx,
    input wire logic clr_valid,
    input wire logic [VW-1:0] clr_idx,
    input wire logic [VW-1:0] bit_idx,
    output logic bit_q,
    input wire logic [PWW-1:0] word_idx,
    output logic [31:0] word_q
);
    if (VEC % 32 != 0 || (1 << VW) < VEC ||
        (1 << PWW) < VEC / 32) begin : g_chk
        $error("peig_pba: unsupported parameters");
    end

    typedef struct packed {
        logic [VEC-1:0] bits;
        logic bit_r;
        logic [31:0] word;
    } peig_pba_st_t;

    peig_pba_st_t s_q;
    peig_pba_st_t s_d;

    always_comb begin
        s_d = s_q;
        if (clr_valid) begin
            s_d.bits[clr_idx] = 1'b0;
        end
        // Set after clear so a new event is never lost
        if (set_valid) begin
            s_d.bits[set_idx] = 1'b1;
        end
        s_d.bit_r = s_q.bits[bit_idx];
        s_d.word = s_q.bits[word_idx*32 +: 32];
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign bit_q = s_q.bit_r;
    assign word_q = s_q.word;

    property p_set_wins;
        @(posedge clk) disable iff (!rst_n)
        set_valid |=> s_q.bits[$past(set_idx)];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("pending bit lost on set");
endmodule : peig_pba

// >>> hw/peig_ctrl.sv
// Implementation choice: register access over AXI4-Lite.
`include "peig_params.svh"

module peig_ctrl #(
    parameter int NUM_FUNC = 8,
    parameter int SPF = 4,
    parameter int VEC = 2048
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [15:0] s_axil_awaddr,
    input wire logic s_axil_awvalid,
    output logic s_axil_awready,
    input wire logic [31:0] s_axil_wdata,
    input wire logic [3:0] s_axil_wstrb,
    input wire logic s_axil_wvalid,
    output logic s_axil_wready,
    output logic [1:0] s_axil_bresp,
    output logic s_axil_bvalid,
    input wire logic s_axil_bready,
    input wire logic [15:0] s_axil_araddr,
    input wire logic s_axil_arvalid,
    output logic s_axil_arready,
    output logic [31:0] s_axil_rdata,
    output logic [1:0] s_axil_rresp,
    output logic s_axil_rvalid,
    input wire logic s_axil_rready,
    input wire logic [NUM_FUNC*SPF-1:0] src_evt_in,
    input wire logic [31:0] msi_evt_in,
    input wire logic msix_evt_valid,
    input wire logic [$clog2(VEC)-1:0] msix_evt_vec,
    output logic [NUM_FUNC-1:0] function_intx_level_in,
    input wire logic core_intx_level_out,
    output logic msi_pend_wr_valid,
    output logic [31:0] msi_pend_wr_data,
    input wire logic msi_pend_wr_ready,
    output logic msix_wr_valid,
    output logic [63:0] msix_wr_addr,
    output logic [31:0] msix_wr_data,
    input wire logic msix_wr_ready,
    output peig_pkg::peig_mx_st_t msix_state
);
    import peig_pkg::*;

    localparam int NUM_SRC = NUM_FUNC * SPF;
    localparam int VW = $clog2(VEC);
    localparam int TAW = VW + 2;
    localparam int PW = VEC / 32;
    localparam int PWW = (PW > 1) ? $clog2(PW) : 1;

    if (NUM_SRC > 32 || NUM_FUNC > 8 || VEC < 32 || VEC > 2048 ||
        (VEC & (VEC - 1)) != 0) begin : g_chk
        $error("peig_ctrl: unsupported parameters");
    end

    typedef struct packed {
        logic aw_have;
        logic [15:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic r_busy;
        logic [15:0] ar_addr;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic leg_en;
        logic msix_en;
        logic [NUM_SRC-1:0] src;
        logic [NUM_FUNC-1:0] lvl;
        logic [31:0] msi;
        logic [31:0] msi_sent;
        logic pu_valid;
        logic [31:0] pu_data;
        peig_mx_st_t st;
        logic [VW-1:0] idx;
        logic [2:0] step;
        logic [63:0] mx_addr;
        logic [31:0] mx_data;
        logic mx_valid;
    } peig_state_t;

    peig_state_t s_q;
    peig_state_t s_d;

    logic wr_fire;
    logic [31:0] wmask;
    logic [NUM_SRC-1:0] src_clr;
    logic [31:0] msi_clr;
    logic tbl_we;
    logic pba_clr;
    logic chk_hit;
    logic [31:0] ra_data;
    logic [31:0] rb_data;
    logic pba_bit;
    logic [31:0] pba_word;

    function automatic logic tbl_hit(input logic [15:0] a);
        return a[15] && ({1'b0, a[14:2]} < 14'(VEC * 4));
    endfunction : tbl_hit

    function automatic logic pba_hit(input logic [15:0] a);
        return (a[15:8] == `PEIG_PBA_PAGE) && ({1'b0, a[7:2]} < 7'(PW));
    endfunction : pba_hit

    function automatic logic reg_hit(input logic [15:0] a);
        return a == `PEIG_REG_CTRL || a == `PEIG_REG_SRC ||
            a == `PEIG_REG_MSI || a == `PEIG_REG_STAT ||
            tbl_hit(a) || pba_hit(a);
    endfunction : reg_hit

    assign s_axil_awready = !s_q.aw_have;
    assign s_axil_wready = !s_q.w_have;
    assign s_axil_arready = !s_q.r_busy && !s_q.rvalid;
    assign wr_fire = s_q.aw_have && s_q.w_have && !s_q.bvalid;
    assign tbl_we = wr_fire && tbl_hit(s_q.aw_addr);
    assign pba_clr = (s_q.st == PEIG_SEND) && msix_wr_ready;
    assign chk_hit = (s_q.st == PEIG_CHK) && pba_bit;

    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wmask[b*8 +: 8] = {8{s_q.w_strb[b]}};
        end
        src_clr = '0;
        msi_clr = '0;
        if (wr_fire && s_q.aw_addr == `PEIG_REG_SRC) begin
            src_clr = s_q.w_data[NUM_SRC-1:0] & wmask[NUM_SRC-1:0];
        end
        if (wr_fire && s_q.aw_addr == `PEIG_REG_MSI) begin
            msi_clr = s_q.w_data & wmask;
        end
    end

    always_comb begin
        s_d = s_q;
        // Write channels are taken independently, in either order
        if (s_axil_awvalid && s_axil_awready) begin
            s_d.aw_have = 1'b1;
            s_d.aw_addr = s_axil_awaddr;
        end
        if (s_axil_wvalid && s_axil_wready) begin
            s_d.w_have = 1'b1;
            s_d.w_data = s_axil_wdata;
            s_d.w_strb = s_axil_wstrb;
        end
        if (s_q.bvalid && s_axil_bready) begin
            s_d.bvalid = 1'b0;
        end
        if (wr_fire) begin
            s_d.aw_have = 1'b0;
            s_d.w_have = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = reg_hit(s_q.aw_addr) ? `PEIG_RESP_OKAY :
                `PEIG_RESP_SLVERR;
            if (s_q.aw_addr == `PEIG_REG_CTRL && s_q.w_strb[0]) begin
                s_d.leg_en = s_q.w_data[`PEIG_CTRL_LEG_BIT];
                s_d.msix_en = s_q.w_data[`PEIG_CTRL_MSIX_BIT];
            end
        end
        // Read: one cycle to fetch, then the answer
        if (s_axil_arvalid && s_axil_arready) begin
            s_d.r_busy = 1'b1;
            s_d.ar_addr = s_axil_araddr;
        end
        if (s_q.rvalid && s_axil_rready) begin
            s_d.rvalid = 1'b0;
        end
        if (s_q.r_busy) begin
            s_d.r_busy = 1'b0;
            s_d.rvalid = 1'b1;
            s_d.rresp = reg_hit(s_q.ar_addr) ? `PEIG_RESP_OKAY :
                `PEIG_RESP_SLVERR;
            s_d.rdata = 32'h0000_0000;
            if (s_q.ar_addr == `PEIG_REG_CTRL) begin
                s_d.rdata[`PEIG_CTRL_LEG_BIT] = s_q.leg_en;
                s_d.rdata[`PEIG_CTRL_MSIX_BIT] = s_q.msix_en;
            end else if (s_q.ar_addr == `PEIG_REG_SRC) begin
                s_d.rdata[NUM_SRC-1:0] = s_q.src;
            end else if (s_q.ar_addr == `PEIG_REG_MSI) begin
                s_d.rdata = s_q.msi;
            end else if (s_q.ar_addr == `PEIG_REG_STAT) begin
                s_d.rdata[`PEIG_STAT_CORE_BIT] = core_intx_level_out;
                s_d.rdata[`PEIG_STAT_BUSY_BIT] = s_q.st != PEIG_IDLE;
                s_d.rdata[`PEIG_STAT_LVL_POS +: NUM_FUNC] = s_q.lvl;
            end else if (tbl_hit(s_q.ar_addr)) begin
                s_d.rdata = ra_data;
            end else if (pba_hit(s_q.ar_addr)) begin
                s_d.rdata = pba_word;
            end
        end
        // Sticky sources, a new event beats a clear
        s_d.src = (s_q.src & ~src_clr) | src_evt_in;
        s_d.msi = (s_q.msi & ~msi_clr) | msi_evt_in;
        for (int f = 0; f < NUM_FUNC; f++) begin
            s_d.lvl[f] = s_q.leg_en && (|s_q.src[f*SPF +: SPF]);
        end
        s_d.lvl[0] = s_d.lvl[0] | core_intx_level_out;
        // Push the MSI pending set to the device whenever it differs from the last set sent
        if (s_q.pu_valid && msi_pend_wr_ready) begin
            s_d.pu_valid = 1'b0;
        end else if (!s_q.pu_valid && s_q.msi != s_q.msi_sent) begin
            s_d.pu_valid = 1'b1;
            s_d.pu_data = s_q.msi;
            s_d.msi_sent = s_q.msi;
        end
        // MSI-X scanner: pending and unmasked vectors are sent
        case (s_q.st)
            PEIG_IDLE: begin
                if (s_q.msix_en) begin
                    s_d.st = PEIG_CHK;
                end
            end
            PEIG_CHK: begin
                if (pba_bit) begin
                    s_d.st = PEIG_RD;
                    s_d.step = 3'd0;
                end else begin
                    s_d.idx = s_q.idx + 1'b1;
                    s_d.st = PEIG_IDLE;
                end
            end
            PEIG_RD: begin
                s_d.step = s_q.step + 3'd1;
                case (s_q.step)
                    3'd1: s_d.mx_addr[31:0] = rb_data;
                    3'd2: s_d.mx_addr[63:32] = rb_data;
                    3'd3: s_d.mx_data = rb_data;
                    3'd4: begin
                        if (rb_data[`PEIG_MX_MASK_BIT]) begin
                            s_d.idx = s_q.idx + 1'b1;
                            s_d.st = PEIG_IDLE;
                        end else begin
                            s_d.mx_valid = 1'b1;
                            s_d.st = PEIG_SEND;
                        end
                    end
                    default: begin
                    end
                endcase
            end
            PEIG_SEND: begin
                if (msix_wr_ready) begin
                    s_d.mx_valid = 1'b0;
                    s_d.idx = s_q.idx + 1'b1;
                    s_d.st = PEIG_IDLE;
                end
            end
            default: s_d.st = PEIG_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.leg_en <= `PEIG_LEG_EN_RST;
            s_q.msix_en <= `PEIG_MSIX_EN_RST;
        end else begin
            s_q <= s_d;
        end
    end

    peig_tbl_mem #(
        .DEPTH(VEC * `PEIG_MX_DWORDS),
        .AW(TAW)
    ) u_tbl (
        .clk(clk),
        .rst_n(rst_n),
        .we(tbl_we),
        .waddr(s_q.aw_addr[TAW+1:2]),
        .wdata(s_q.w_data),
        .wstrb(s_q.w_strb),
        .ra_addr(s_axil_araddr[TAW+1:2]),
        .ra_data(ra_data),
        .rb_addr({s_q.idx, s_q.step[1:0]}),
        .rb_data(rb_data)
    );

    peig_pba #(
        .VEC(VEC),
        .VW(VW),
        .PWW(PWW)
    ) u_pba (
        .clk(clk),
        .rst_n(rst_n),
        .set_valid(msix_evt_valid),
        .set_idx(msix_evt_vec),
        .clr_valid(pba_clr),
        .clr_idx(s_q.idx),
        .bit_idx(s_q.idx),
        .bit_q(pba_bit),
        .word_idx(s_axil_araddr[PWW+1:2]),
        .word_q(pba_word)
    );

    assign s_axil_bvalid = s_q.bvalid;
    assign s_axil_bresp = s_q.bresp;
    assign s_axil_rvalid = s_q.rvalid;
    assign s_axil_rdata = s_q.rdata;
    assign s_axil_rresp = s_q.rresp;
    assign function_intx_level_in = s_q.lvl;
    assign msi_pend_wr_valid = s_q.pu_valid;
    assign msi_pend_wr_data = s_q.pu_data;
    assign msix_wr_valid = s_q.mx_valid;
    assign msix_wr_addr = s_q.mx_addr;
    assign msix_wr_data = s_q.mx_data;
    assign msix_state = s_q.st;

    property p_legacy_or;
        @(posedge clk) disable iff (!rst_n)
        (s_q.leg_en && s_q.src[0]) |=> function_intx_level_in[0];
    endproperty
    a_legacy_or: assert property (p_legacy_or)
        else $error("source not seen on function level");

    property p_src_hold;
        @(posedge clk) disable iff (!rst_n)
        (s_q.src[0] && !src_clr[0]) |=> s_q.src[0];
    endproperty
    a_src_hold: assert property (p_src_hold)
        else $error("source dropped without a clear");

    property p_core_merge;
        @(posedge clk) disable iff (!rst_n)
        core_intx_level_out |=> function_intx_level_in[0];
    endproperty
    a_core_merge: assert property (p_core_merge)
        else $error("core interrupt not merged");

    property p_pend_update;
        @(posedge clk) disable iff (!rst_n)
        (s_q.msi != s_q.msi_sent && !s_q.pu_valid) |=>
            (msi_pend_wr_valid && msi_pend_wr_data == $past(s_q.msi));
    endproperty
    a_pend_update: assert property (p_pend_update)
        else $error("pending change not written");

    property p_pend_hold;
        @(posedge clk) disable iff (!rst_n)
        (msi_pend_wr_valid && !msi_pend_wr_ready) |=>
            (msi_pend_wr_valid && $stable(msi_pend_wr_data));
    endproperty
    a_pend_hold: assert property (p_pend_hold)
        else $error("pending write not held");

    property p_entry_use;
        @(posedge clk) disable iff (!rst_n)
        $rose(msix_wr_valid) |-> (msix_wr_data == $past(rb_data, 2) &&
            msix_wr_addr == {$past(rb_data, 3), $past(rb_data, 4)});
    endproperty
    a_entry_use: assert property (p_entry_use)
        else $error("write not built from table entry");

    property p_mask_skip;
        @(posedge clk) disable iff (!rst_n)
        (s_q.st == PEIG_RD && s_q.step == 3'd4 && rb_data[0]) |=>
            (s_q.st == PEIG_IDLE && !msix_wr_valid);
    endproperty
    a_mask_skip: assert property (p_mask_skip)
        else $error("masked vector was sent");

    property p_send_pending;
        @(posedge clk) disable iff (!rst_n)
        $rose(msix_wr_valid) |-> $past(chk_hit, 6);
    endproperty
    a_send_pending: assert property (p_send_pending)
        else $error("write sent without pending bit");

    property p_clear_after;
        @(posedge clk) disable iff (!rst_n)
        (msix_wr_valid && msix_wr_ready) |-> pba_clr ##1 !msix_wr_valid;
    endproperty
    a_clear_after: assert property (p_clear_after)
        else $error("pending not cleared after send");

    property p_axil_read;
        @(posedge clk) disable iff (!rst_n)
        (s_axil_arvalid && s_axil_arready) |=> ##1 s_axil_rvalid;
    endproperty
    a_axil_read: assert property (p_axil_read)
        else $error("read answer late");

    property p_tbl_write;
        @(posedge clk) disable iff (!rst_n)
        tbl_we |=> (s_axil_bvalid && s_axil_bresp == `PEIG_RESP_OKAY);
    endproperty
    a_tbl_write: assert property (p_tbl_write)
        else $error("table write not answered");
endmodule : peig_ctrl

// >>> tb/peig_dev_model.sv
module peig_dev_model #(
    parameter int NF = 2,
    parameter logic [2*NF-1:0] INTX_SEL = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cap_irq,
    input wire logic slow,
    input wire logic [NF-1:0] function_intx_level_in,
    output logic core_intx_level_out,
    input wire logic msi_pend_wr_valid,
    input wire logic [31:0] msi_pend_wr_data,
    output logic msi_pend_wr_ready,
    input wire logic msix_wr_valid,
    input wire logic [63:0] msix_wr_addr,
    input wire logic [31:0] msix_wr_data,
    output logic msix_wr_ready,
    output logic [31:0] msi_pend_q,
    output logic [3:0] wire_lvl_q,
    output int n_assert,
    output int n_deassert,
    output int n_msix,
    output logic [63:0] mx_addr_q,
    output logic [31:0] mx_data_q
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] agg;
    int stall;

    // Per-wire aggregate of all function levels
    always_comb begin
        agg = 4'h0;
        for (int f = 0; f < NF; f++) begin
            if (function_intx_level_in[f]) begin
                agg[INTX_SEL[2*f+:2]] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            core_intx_level_out <= 1'b0;
            msi_pend_wr_ready <= 1'b0;
            msix_wr_ready <= 1'b0;
            msi_pend_q <= 32'h0000_0000;
            wire_lvl_q <= 4'h0;
            n_assert <= 0;
            n_deassert <= 0;
            n_msix <= 0;
            stall <= 0;
            mx_addr_q <= '0;
            mx_data_q <= '0;
        end else begin
            core_intx_level_out <= cap_irq;
            wire_lvl_q <= agg;
            n_assert <= n_assert + $countones(agg & ~wire_lvl_q);
            n_deassert <= n_deassert + $countones(~agg & wire_lvl_q);
            msi_pend_wr_ready <= msi_pend_wr_valid && !msi_pend_wr_ready;
            if (msi_pend_wr_valid && msi_pend_wr_ready) begin
                msi_pend_q <= msi_pend_wr_data;
            end
            // Slow mode stalls each memory write a few cycles
            stall <= (msix_wr_valid && !msix_wr_ready) ? stall + 1 : 0;
            msix_wr_ready <= msix_wr_valid && !msix_wr_ready &&
                             (!slow || stall >= 3);
            if (msix_wr_valid && msix_wr_ready) begin
                n_msix <= n_msix + 1;
                mx_addr_q <= msix_wr_addr;
                mx_data_q <= msix_wr_data;
            end
        end
    end
endmodule : peig_dev_model

// >>> tb/pcie_endpoint_interrupt_generation_bench.sv
`include "peig_params.svh"

module pcie_endpoint_interrupt_generation_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import peig_pkg::*;
    localparam int NF = 2;
    localparam int SPF = 4;
    localparam int VEC = 64;
    localparam logic [31:0] T5 [4] = '{32'hfee0_1000, 32'h0000_0001,
                                       32'h0000_00a5, 32'h0000_0001};
    localparam logic [31:0] T9 [4] = '{32'hfee0_2000, 32'h0000_0000,
                                       32'h0000_005a, 32'h0000_0000};
    logic clk, rst_n, cap_irq, slow;
    logic [15:0] s_axil_awaddr, s_axil_araddr;
    logic [31:0] s_axil_wdata, s_axil_rdata, msi_evt_in, msi_pend_wr_data;
    logic [31:0] msix_wr_data, msi_pend_q, mx_data_q, d;
    logic [3:0] s_axil_wstrb, wire_lvl_q;
    logic [1:0] s_axil_bresp, s_axil_rresp, resp;
    logic s_axil_awvalid, s_axil_awready, s_axil_wvalid, s_axil_wready;
    logic s_axil_bvalid, s_axil_bready, s_axil_arvalid, s_axil_arready;
    logic s_axil_rvalid, s_axil_rready, msix_evt_valid, core_intx_level_out;
    logic msi_pend_wr_valid, msi_pend_wr_ready, msix_wr_valid, msix_wr_ready;
    logic [NF*SPF-1:0] src_evt_in;
    logic [$clog2(VEC)-1:0] msix_evt_vec;
    logic [NF-1:0] function_intx_level_in;
    logic [63:0] msix_wr_addr, mx_addr_q;
    peig_mx_st_t msix_state;
    int n_errors, checked, n_assert, n_deassert, n_msix;

    peig_ctrl #(.NUM_FUNC(NF), .SPF(SPF), .VEC(VEC)) dut (
        .clk, .rst_n, .s_axil_awaddr, .s_axil_awvalid, .s_axil_awready,
        .s_axil_wdata, .s_axil_wstrb, .s_axil_wvalid, .s_axil_wready,
        .s_axil_bresp, .s_axil_bvalid, .s_axil_bready, .s_axil_araddr,
        .s_axil_arvalid, .s_axil_arready, .s_axil_rdata, .s_axil_rresp,
        .s_axil_rvalid, .s_axil_rready, .src_evt_in, .msi_evt_in,
        .msix_evt_valid, .msix_evt_vec, .function_intx_level_in,
        .core_intx_level_out, .msi_pend_wr_valid, .msi_pend_wr_data,
        .msi_pend_wr_ready, .msix_wr_valid, .msix_wr_addr, .msix_wr_data,
        .msix_wr_ready, .msix_state);

    peig_dev_model #(.NF(NF)) dev (
        .clk, .rst_n, .cap_irq, .slow, .function_intx_level_in,
        .core_intx_level_out, .msi_pend_wr_valid, .msi_pend_wr_data,
        .msi_pend_wr_ready, .msix_wr_valid, .msix_wr_addr, .msix_wr_data,
        .msix_wr_ready, .msi_pend_q, .wire_lvl_q, .n_assert, .n_deassert,
        .n_msix, .mx_addr_q, .mx_data_q);

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : stop_test

    task automatic chk(input string what, input logic [63:0] exp,
                       input logic [63:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [31:0] v);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        s_axil_awaddr <= a;
        s_axil_wdata <= v;
        s_axil_awvalid <= 1'b1;
        s_axil_wvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axil_awvalid && s_axil_awready) begin
                aw = 1'b1;
                s_axil_awvalid <= 1'b0;
            end
            if (s_axil_wvalid && s_axil_wready) begin
                w = 1'b1;
                s_axil_wvalid <= 1'b0;
            end
        end while (!(aw && w));
        s_axil_bready <= 1'b1;
        do @(posedge clk); while (!s_axil_bvalid);
        resp = s_axil_bresp;
        s_axil_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [15:0] a);
        s_axil_araddr <= a;
        s_axil_arvalid <= 1'b1;
        do @(posedge clk); while (!s_axil_arready);
        s_axil_arvalid <= 1'b0;
        s_axil_rready <= 1'b1;
        do @(posedge clk); while (!s_axil_rvalid);
        d = s_axil_rdata;
        resp = s_axil_rresp;
        s_axil_rready <= 1'b0;
    endtask : rd

    // One-cycle source event, then time for levels to settle
    task automatic pulse(input logic [NF*SPF-1:0] v);
        src_evt_in <= v;
        @(posedge clk);
        src_evt_in <= '0;
        repeat (4) @(posedge clk);
    endtask : pulse

    task automatic wait_mx(input int n);
        int k;
        k = 0;
        while (n_msix != n && k < 2000) begin
            @(posedge clk);
            k++;
        end
        chk("nmx", n, n_msix);
    endtask : wait_mx

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        stop_test();
    end

    initial begin
        {rst_n, cap_irq, slow, s_axil_awvalid, s_axil_wvalid} = '0;
        {s_axil_bready, s_axil_arvalid, s_axil_rready, msix_evt_valid} = '0;
        {s_axil_awaddr, s_axil_araddr, s_axil_wdata, msi_evt_in} = '0;
        {src_evt_in, msix_evt_vec} = '0;
        s_axil_wstrb = 4'hf;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        rd(`PEIG_REG_CTRL);
        chk("ctrl", 32'h0000_0001, d);
        chk("rresp", `PEIG_RESP_OKAY, resp);
        rd(`PEIG_REG_STAT);
        chk("stat", 32'h0000_0000, d);
        chk("mxst", PEIG_IDLE, msix_state);
        pulse(8'h50);
        chk("lvl", 2'b10, function_intx_level_in);
        chk("asrt", 1, n_assert);
        rd(`PEIG_REG_SRC);
        chk("src", 32'h0000_0050, d);
        wr(`PEIG_REG_SRC, 32'h0000_0010);
        pulse(8'h01);
        chk("lvl", 2'b11, function_intx_level_in);
        chk("asrt", 1, n_assert);
        wr(`PEIG_REG_SRC, 32'h0000_0040);
        pulse(8'h00);
        chk("lvl", 2'b01, function_intx_level_in);
        wr(`PEIG_REG_SRC, 32'h0000_0001);
        pulse(8'h00);
        chk("lvl", 2'b00, function_intx_level_in);
        chk("dasrt", 1, n_deassert);
        cap_irq <= 1'b1;
        pulse(8'h00);
        chk("lvl", 2'b01, function_intx_level_in);
        rd(`PEIG_REG_STAT);
        chk("stat", 32'h0000_0101, d);
        cap_irq <= 1'b0;
        pulse(8'h00);
        chk("dasrt", 2, n_deassert);
        wr(`PEIG_REG_CTRL, 32'h0000_0000);
        pulse(8'h10);
        chk("lvl", 2'b00, function_intx_level_in);
        wr(`PEIG_REG_CTRL, 32'h0000_0001);
        pulse(8'h00);
        chk("lvl", 2'b10, function_intx_level_in);
        chk("asrt", 3, n_assert);
        wr(`PEIG_REG_SRC, 32'h0000_0010);
        pulse(8'h00);
        chk("dasrt", 3, n_deassert);
        msi_evt_in <= 32'h8000_0021;
        @(posedge clk);
        msi_evt_in <= '0;
        repeat (10) @(posedge clk);
        chk("msip", 32'h8000_0021, msi_pend_q);
        rd(`PEIG_REG_MSI);
        chk("msi", 32'h8000_0021, d);
        wr(`PEIG_REG_MSI, 32'h0000_0001);
        repeat (10) @(posedge clk);
        chk("msip", 32'h8000_0020, msi_pend_q);
        for (int i = 0; i < 4; i++) begin
            wr(16'h8050 + 16'(4 * i), T5[i]);
            wr(16'h8090 + 16'(4 * i), T9[i]);
        end
        rd(16'h805C);
        chk("tbl", 32'h0000_0001, d);
        wr(`PEIG_REG_CTRL, 32'h0000_0003);
        slow <= 1'b1;
        msix_evt_valid <= 1'b1;
        msix_evt_vec <= 6'd5;
        @(posedge clk);
        msix_evt_vec <= 6'd9;
        @(posedge clk);
        msix_evt_valid <= 1'b0;
        wait_mx(1);
        chk("mxa", {32'h0000_0000, T9[0]}, mx_addr_q);
        chk("mxd", T9[2], mx_data_q);
        repeat (400) @(posedge clk);
        chk("nmx", 1, n_msix);
        rd(16'h1000);
        chk("pba", 32'h0000_0020, d);
        rd(16'h1004);
        chk("pba1", 32'h0000_0000, d);
        slow <= 1'b0;
        wr(16'h805C, 32'h0000_0000);
        wait_mx(2);
        chk("mxa", {T5[1], T5[0]}, mx_addr_q);
        chk("mxd", T5[2], mx_data_q);
        repeat (4) @(posedge clk);
        rd(16'h1000);
        chk("pba", 32'h0000_0000, d);
        rd(16'h0020);
        chk("rresp", `PEIG_RESP_SLVERR, resp);
        chk("rdat", 32'h0000_0000, d);
        wr(16'h0020, 32'h0000_0001);
        chk("bresp", `PEIG_RESP_SLVERR, resp);
        wr(16'h1000, 32'hffff_ffff);
        chk("bresp", `PEIG_RESP_OKAY, resp);
        rd(16'h1000);
        chk("pba", 32'h0000_0000, d);
        stop_test();
    end
endmodule : pcie_endpoint_interrupt_generation_bench
